// File: rtl/esw_pkg.sv
// esw_pkg: constants and types shared by the mode/wake controller and its host end
// assumes a 200 MHz ref_clk and a synchronous active-high reset
package esw_pkg;

  localparam int unsigned CLK_MHZ          = 200;
  // times in their printed units
  localparam int unsigned GATE_OFF_NS      = 100;
  localparam int unsigned MODE_DELAY_US    = 1000;
  localparam int unsigned WAKE_LOW_US      = 250;
  localparam int unsigned LIN_DOM_US       = 150;
  localparam int unsigned LIN_MASTER_US    = 250;
  // cycle counts: least times round up, longest round down
  localparam int unsigned GATE_OFF_CYC     = (GATE_OFF_NS * CLK_MHZ) / 1000;
  localparam int unsigned MODE_DELAY_CYC   = MODE_DELAY_US * CLK_MHZ;
  localparam int unsigned WAKE_LOW_CYC     = WAKE_LOW_US * CLK_MHZ;
  localparam int unsigned LIN_DOM_CYC      = LIN_DOM_US * CLK_MHZ;
  localparam int unsigned LIN_MASTER_CYC   = LIN_MASTER_US * CLK_MHZ + 1;
  localparam int unsigned TIMER_W          = 18;

  localparam int unsigned PHASES           = 3;
  localparam int unsigned DEAD_W           = 8;
  localparam logic [DEAD_W-1:0] DEAD_RESET = 8'h00;
  localparam logic        SLEEP_SEL_RESET  = 1'b0;
  localparam logic        PULLUP_RESET     = 1'b1;

  // variant select
  localparam logic [0:0] VARIANT_LIN       = 1'h0;
  localparam logic [0:0] VARIANT_XLATE     = 1'h1;

  typedef enum logic [1:0]
  {
    MODE_NORMAL  = 2'b00,
    MODE_PENDING = 2'b01,
    MODE_STANDBY = 2'b10,
    MODE_SLEEP   = 2'b11
  } esw_mode_t;

endpackage : esw_pkg

// File: rtl/esw_link_if.sv
// esw_link_if: pins between the host and the gate driver's control logic
// open-drain pins carry an output enable; the bench resolves only the LIN bus level
`timescale 1ns/1ps
interface esw_link_if;
  import esw_pkg::*;
  logic               chip_on;
  logic [PHASES-1:0]  high_cmd;
  logic [PHASES-1:0]  low_cmd;
  logic [PHASES-1:0]  gate_high;
  logic [PHASES-1:0]  gate_low;
  logic               lin_tx;
  logic               lin_bus_in;
  logic               lin_bus_oe;
  logic               lin_bus_host_oe;
  logic               lin_pullup_on;
  logic               high_volt_input_1;
  logic               high_volt_input_2;
  logic               hv_pullup_on;
  logic               logic_level_output_1_oe;
  logic               logic_level_output_2_oe;
  logic [1:0]         mode;

  modport dev
  (
    input  chip_on, high_cmd, low_cmd, lin_tx, lin_bus_in,
    input  high_volt_input_1, high_volt_input_2,
    output gate_high, gate_low, lin_bus_oe, lin_pullup_on, hv_pullup_on,
    output logic_level_output_1_oe, logic_level_output_2_oe, mode
  );
  modport host
  (
    output chip_on, high_cmd, low_cmd, lin_tx, lin_bus_host_oe,
    input  gate_high, gate_low, mode
  );
endinterface : esw_link_if

// File: rtl/esw_device.sv
// esw_device: mode, wake, gate-enable and pin control of a three-phase gate driver
// assumes all link inputs are asynchronous pins; config bits come from a static strap/port
`timescale 1ns/1ps
module esw_device
#(
  parameter logic [0:0]  VARIANT       = esw_pkg::VARIANT_LIN,
  parameter int unsigned MODE_DELAY    = esw_pkg::MODE_DELAY_CYC,
  parameter int unsigned WAKE_LOW      = esw_pkg::WAKE_LOW_CYC,
  parameter int unsigned LIN_DOM       = esw_pkg::LIN_DOM_CYC
)
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  esw_link_if.dev                         link,
  input  wire logic                       sleep_select,
  input  wire logic                       weak_pullup_bit,
  input  wire logic [esw_pkg::DEAD_W-1:0] third_config_reg,
  input  wire logic                       fault_active,
  output logic                            fault_latched,
  output logic                            amps_on,
  output logic                            high_reg_on,
  output logic                            low_reg_on,
  output logic                            buck_on
);
  import esw_pkg::*;

  // three-stage pin synchronisers; only stages 2 and 3 are looked at
  localparam int unsigned NPIN = 2 + 2 * PHASES + 2;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin_q;
  // bus and transmit data idle high: a zero reset would fake a bus edge
  localparam logic [NPIN-1:0] PIN_IDLE = {1'b1, {(NPIN-2){1'b0}}, 1'b1};

  // an undriven bus pin resolves high through the pull-up on the wire before reaching here
  assign pin_raw = {link.lin_bus_in, link.high_volt_input_1,
                    link.high_cmd, link.low_cmd, link.chip_on, link.lin_tx};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          pin_q[gi] <= PIN_IDLE[gi];
        else if (sync2[gi] == sync3[gi])
          pin_q[gi] <= sync3[gi];
      end
    end
  endgenerate

  logic              tx_q;
  logic              ce_q;
  logic [PHASES-1:0] lo_q;
  logic [PHASES-1:0] hi_q;
  logic              hv1_q;
  logic              bus_q;
  assign {bus_q, hv1_q, hi_q, lo_q, ce_q, tx_q} = pin_q;

  // chip-on low seen two stages earlier: gates drop without the debounce wait
  logic ce_fast_low;
  assign ce_fast_low = ~sync2[1];

  logic ce_prev;
  logic hv1_prev;
  logic bus_prev;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ce_prev  <= 1'b0;
      hv1_prev <= 1'b0;
      bus_prev <= 1'b1;
    end
    else
    begin
      ce_prev  <= ce_q;
      hv1_prev <= hv1_q;
      bus_prev <= bus_q;
    end
  end
  logic ce_rise;
  logic hv1_rise;
  logic bus_rise;
  assign ce_rise  = ce_q & ~ce_prev;
  assign hv1_rise = hv1_q & ~hv1_prev;
  assign bus_rise = bus_q & ~bus_prev;

  // low-time counters, saturating; one per watched pin
  logic [TIMER_W-1:0] ce_low_cnt;
  logic [TIMER_W-1:0] hv1_low_cnt;
  logic [TIMER_W-1:0] dom_cnt;
  always_ff @(posedge ref_clk)
  begin
    if (rst || ce_q)
      ce_low_cnt <= '0;
    else if (ce_low_cnt != {TIMER_W{1'b1}})
      ce_low_cnt <= ce_low_cnt + 1'b1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || hv1_q)
      hv1_low_cnt <= '0;
    else if (hv1_low_cnt != {TIMER_W{1'b1}})
      hv1_low_cnt <= hv1_low_cnt + 1'b1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || bus_q)
      dom_cnt <= '0;
    else if (dom_cnt != {TIMER_W{1'b1}})
      dom_cnt <= dom_cnt + 1'b1;
  end

  logic hv1_armed;
  logic dom_armed;
  logic ce_armed;
  assign ce_armed  = 32'(ce_prev ? 0 : ce_low_cnt) >= WAKE_LOW;
  assign hv1_armed = 32'(hv1_low_cnt) > WAKE_LOW;
  assign dom_armed = 32'(dom_cnt) > LIN_DOM;

  esw_mode_t mode;
  logic      wake_ok;
  assign wake_ok = (ce_rise && ce_armed)
                || (VARIANT == VARIANT_XLATE && hv1_rise && hv1_armed)
                || (VARIANT == VARIANT_LIN && bus_rise && dom_armed);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mode <= MODE_STANDBY;
    else
    begin
      case (mode)
        MODE_NORMAL:
          if (!ce_q)
            mode <= MODE_PENDING;
        MODE_PENDING:
          if (ce_q)
            mode <= MODE_NORMAL;
          else if (32'(ce_low_cnt) >= MODE_DELAY)
            mode <= sleep_select ? MODE_SLEEP : MODE_STANDBY;
        MODE_STANDBY:
          if (ce_q)
            mode <= MODE_NORMAL;
        MODE_SLEEP:
          if (wake_ok)
            mode <= ce_q ? MODE_NORMAL : MODE_STANDBY;
        default:
          mode <= MODE_STANDBY;
      endcase
    end
  end

  // hardware keeps setting while the cause persists, so set beats clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      fault_latched <= 1'b0;
    else if (fault_active)
      fault_latched <= 1'b1;
    else if (ce_rise)
      fault_latched <= 1'b0;
  end

  // power rails follow the mode
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      amps_on     <= 1'b0;
      high_reg_on <= 1'b0;
      low_reg_on  <= 1'b0;
      buck_on     <= 1'b0;
    end
    else
    begin
      amps_on     <= ce_q && mode != MODE_SLEEP;
      high_reg_on <= ce_q && mode != MODE_SLEEP;
      low_reg_on  <= mode != MODE_SLEEP
                  && (VARIANT == VARIANT_LIN || ce_q);
      buck_on     <= mode != MODE_SLEEP;
    end
  end

  // dead time per phase: a side turns on only after the other has been off long enough
  logic [DEAD_W-1:0] hi_off_cnt [PHASES];
  logic [DEAD_W-1:0] lo_off_cnt [PHASES];
  generate
    for (gi = 0; gi < PHASES; gi++)
    begin : g_phase
      always_ff @(posedge ref_clk)
      begin
        if (rst || link.gate_high[gi])
          hi_off_cnt[gi] <= '0;
        else if (hi_off_cnt[gi] != {DEAD_W{1'b1}})
          hi_off_cnt[gi] <= hi_off_cnt[gi] + 1'b1;
      end
      always_ff @(posedge ref_clk)
      begin
        if (rst || link.gate_low[gi])
          lo_off_cnt[gi] <= '0;
        else if (lo_off_cnt[gi] != {DEAD_W{1'b1}})
          lo_off_cnt[gi] <= lo_off_cnt[gi] + 1'b1;
      end
      always_ff @(posedge ref_clk)
      begin
        // gates wait for the normal state so they never lead the mode output
        if (rst || ce_fast_low || !ce_q || mode != MODE_NORMAL
            || (hi_q[gi] && lo_q[gi]))
        begin
          link.gate_high[gi] <= 1'b0;
          link.gate_low[gi]  <= 1'b0;
        end
        else
        begin
          link.gate_high[gi] <= hi_q[gi] && !link.gate_low[gi]
                             && lo_off_cnt[gi] >= third_config_reg;
          link.gate_low[gi]  <= lo_q[gi] && !link.gate_high[gi]
                             && hi_off_cnt[gi] >= third_config_reg;
        end
      end
    end
  endgenerate

  // pins: translators, LIN driver and pull-ups
  logic pullup_sample;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pullup_sample <= PULLUP_RESET;
    else if (!ce_q)
      pullup_sample <= weak_pullup_bit;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      link.lin_bus_oe              <= 1'b0;
      link.lin_pullup_on           <= 1'b0;
      link.hv_pullup_on            <= 1'b0;
      link.logic_level_output_1_oe <= 1'b0;
      link.logic_level_output_2_oe <= 1'b0;
      link.mode                    <= MODE_STANDBY;
    end
    else
    begin
      // pulled low only; released means the external pull-up sets the level
      link.lin_bus_oe              <= VARIANT == VARIANT_LIN && ce_q && !tx_q;
      link.lin_pullup_on           <= VARIANT == VARIANT_LIN
                                   && (mode == MODE_NORMAL || mode == MODE_PENDING
                                   || (mode == MODE_STANDBY && pullup_sample));
      link.hv_pullup_on            <= VARIANT == VARIANT_XLATE && pullup_sample;
      link.logic_level_output_1_oe <= VARIANT == VARIANT_XLATE
                                   && mode != MODE_SLEEP && !hv1_q;
      link.logic_level_output_2_oe <= VARIANT == VARIANT_XLATE
                                   && mode != MODE_SLEEP && !link.high_volt_input_2;
      link.mode                    <= mode;
    end
  end

endmodule : esw_device

// File: rtl/esw_host.sv
// esw_host: host end that drives chip-on, gate commands and LIN wake pulses
// assumes a user side on the same ref_clk; waits are counted in that clock
`timescale 1ns/1ps
module esw_host
#(
  parameter int unsigned WAKE_LOW   = esw_pkg::WAKE_LOW_CYC,
  parameter int unsigned LIN_MASTER = esw_pkg::LIN_MASTER_CYC
)
(
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  esw_link_if.host                         link,
  input  wire logic                        enable_req,
  input  wire logic                        fault_clear_req,
  input  wire logic                        lin_wake_req,
  input  wire logic [esw_pkg::PHASES-1:0]  user_high,
  input  wire logic [esw_pkg::PHASES-1:0]  user_low,
  input  wire logic                        user_tx,
  output logic                             busy
);
  import esw_pkg::*;

  logic [TIMER_W-1:0] cnt;
  logic               lin_wake;
  logic               clear_pulse;

  // fault clear is a four-cycle low dip, well below the mode delay
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt         <= '0;
      lin_wake    <= 1'b0;
      clear_pulse <= 1'b0;
      busy        <= 1'b0;
    end
    else if (busy)
    begin
      cnt <= cnt - 1'b1;
      if (cnt == '0)
      begin
        busy        <= 1'b0;
        lin_wake    <= 1'b0;
        clear_pulse <= 1'b0;
      end
    end
    else if (lin_wake_req)
    begin
      cnt      <= TIMER_W'(LIN_MASTER);
      lin_wake <= 1'b1;
      busy     <= 1'b1;
    end
    else if (fault_clear_req)
    begin
      cnt         <= TIMER_W'(3);
      clear_pulse <= 1'b1;
      busy        <= 1'b1;
    end
    else if (!enable_req && link.chip_on)
    begin
      cnt  <= TIMER_W'(WAKE_LOW);
      busy <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      link.chip_on         <= 1'b0;
      link.high_cmd        <= '0;
      link.low_cmd         <= '0;
      link.lin_tx          <= 1'b1;
      link.lin_bus_host_oe <= 1'b0;
    end
    else
    begin
      // chip-on stays low for the whole wait after a drop
      link.chip_on         <= enable_req && !clear_pulse && !(busy && !link.chip_on
                           && !lin_wake && !clear_pulse);
      link.high_cmd        <= user_high & ~user_low;
      link.low_cmd         <= user_low & ~user_high;
      link.lin_tx          <= user_tx;
      link.lin_bus_host_oe <= lin_wake;
    end
  end

endmodule : esw_host

// File: testbench/esw_checker.sv
// esw_checker: link-level assertions for the mode/wake controller
// assumes one ref_clk domain; sits beside the link interface in the bench
`timescale 1ns/1ps
module esw_checker
#(
  parameter int unsigned MODE_DELAY = 40
)
(
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       chip_on,
  input wire logic [esw_pkg::PHASES-1:0] high_cmd,
  input wire logic [esw_pkg::PHASES-1:0] low_cmd,
  input wire logic [esw_pkg::PHASES-1:0] gate_high,
  input wire logic [esw_pkg::PHASES-1:0] gate_low,
  input wire logic                       lin_tx,
  input wire logic                       lin_bus_oe,
  input wire logic                       lin_pullup_on,
  input wire logic [1:0]                 mode
);
  import esw_pkg::*;

  int unsigned low_cnt;

  // saturating count of raw chip-on low cycles
  always_ff @(posedge ref_clk)
  begin
    if (rst || chip_on)
      low_cnt <= 0;
    else if (low_cnt < MODE_DELAY)
      low_cnt <= low_cnt + 1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence hi_cmd_s;
    chip_on && high_cmd[0] && !low_cmd[0] && mode == MODE_NORMAL;
  endsequence

  gate_excl_a:
    assert property (~|(gate_high & gate_low)) else $error("both gates of a phase on");
  gate_off_a:
    assert property ($fell(chip_on) |-> ##[1:4] ~|{gate_high, gate_low})
      else $error("gates not off after chip-on low");
  mode_delay_a:
    assert property ($rose(mode[1]) |-> low_cnt >= MODE_DELAY) else $error("early mode change");
  idle_gates_a:
    assert property (mode[1] |-> ~|{gate_high, gate_low}) else $error("gate on in low power");
  sleep_pullup_a:
    assert property (($stable(mode) && mode == MODE_SLEEP) |-> !lin_pullup_on)
      else $error("pull-up on in sleep");
  run_pullup_a:
    assert property (($stable(mode) && !mode[1]) |-> lin_pullup_on)
      else $error("pull-up off in normal");
  lin_idle_a:
    assert property (lin_tx [*6] |-> !lin_bus_oe) else $error("bus driven while tx high");
  lin_drive_a:
    assert property ((!lin_tx && chip_on && mode == MODE_NORMAL) [*6] |-> lin_bus_oe)
      else $error("bus not driven while tx low");
  dead_time_a:
    assert property ($rose(gate_high[0]) |-> !$past(gate_low[0], 1) && !$past(gate_low[0], 2)
      && !$past(gate_low[0], 3)) else $error("dead time too short");
  gate_follow_a:
    assert property (hi_cmd_s [*8] ##1 hi_cmd_s [*4] |-> gate_high[0])
      else $error("high gate ignores command");
  wake_chip_a:
    assert property (($past(mode) == MODE_SLEEP && mode == MODE_NORMAL) |-> chip_on)
      else $error("woke to normal with chip-on low");

  cover property (mode == MODE_STANDBY);
  cover property (mode == MODE_SLEEP);
  cover property ($past(mode) == MODE_SLEEP && mode != MODE_SLEEP);
endmodule : esw_checker

// File: testbench/enable_sleep_wake_control_tb_top.sv
// enable_sleep_wake_control_tb_top: host end and device joined over the link
// assumes shortened delay parameters; user inputs change on the falling edge
`timescale 1ns/1ps
module enable_sleep_wake_control_tb_top;
  import esw_pkg::*;
  localparam int unsigned MDLY = 40;

  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              sleep_select = 1'b0;
  logic              weak_pullup_bit = 1'b1;
  logic              fault_active = 1'b0;
  logic              fault_latched;
  logic              amps_on;
  logic              high_reg_on;
  logic              low_reg_on;
  logic              buck_on;
  logic              enable_req = 1'b0;
  logic              fault_clear_req = 1'b0;
  logic              lin_wake_req = 1'b0;
  logic [PHASES-1:0] user_high = 3'h0;
  logic [PHASES-1:0] user_low = 3'h0;
  logic              user_tx = 1'b1;
  logic              busy;
  int                miscompares = 0;
  int                tests_run = 0;
  int                cycles = 0;

  esw_link_if link ();
  // open-drain bus with pull-up: low while either end pulls
  assign link.lin_bus_in = ~(link.lin_bus_oe | link.lin_bus_host_oe);
  assign link.high_volt_input_1 = 1'b1;
  assign link.high_volt_input_2 = 1'b1;

  esw_device #(.VARIANT(VARIANT_LIN), .MODE_DELAY(MDLY), .WAKE_LOW(10), .LIN_DOM(6))
  esw_device_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .sleep_select(sleep_select),
    .weak_pullup_bit(weak_pullup_bit), .third_config_reg(8'h03),
    .fault_active(fault_active), .fault_latched(fault_latched), .amps_on(amps_on),
    .high_reg_on(high_reg_on), .low_reg_on(low_reg_on), .buck_on(buck_on));

  esw_host #(.WAKE_LOW(10), .LIN_MASTER(12))
  esw_host_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .enable_req(enable_req),
    .fault_clear_req(fault_clear_req), .lin_wake_req(lin_wake_req),
    .user_high(user_high), .user_low(user_low), .user_tx(user_tx), .busy(busy));

  esw_checker #(.MODE_DELAY(MDLY))
  esw_checker_inst (.ref_clk(ref_clk), .rst(rst), .chip_on(link.chip_on),
    .high_cmd(link.high_cmd), .low_cmd(link.low_cmd), .gate_high(link.gate_high),
    .gate_low(link.gate_low), .lin_tx(link.lin_tx), .lin_bus_oe(link.lin_bus_oe),
    .lin_pullup_on(link.lin_pullup_on), .mode(link.mode));

  initial
    forever #2.5 ref_clk = ~ref_clk;

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic check_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  // busy may linger while the host enforces the minimum low time
  task automatic enable_on;
    int n;
    n = 0;
    enable_req = 1'b1;
    tick(2);
    while (busy !== 1'b0 && n < 100)
    begin
      tick(1);
      n++;
    end
    tick(12);
    check_val("mode", MODE_NORMAL, link.mode);
  endtask : enable_on

  task automatic clear_pulse;
    fault_clear_req = 1'b1;
    tick(1);
    fault_clear_req = 1'b0;
    tick(20);
  endtask : clear_pulse

  task automatic test_enable;
    enable_on();
    check_bit("amps_on", 1'b1, amps_on);
    check_bit("high_reg_on", 1'b1, high_reg_on);
    check_bit("lin_pullup_on", 1'b1, link.lin_pullup_on);
    user_tx = 1'b0;
    tick(8);
    check_bit("lin_bus_oe", 1'b1, link.lin_bus_oe);
    user_tx = 1'b1;
    tick(8);
    check_bit("lin_bus_oe", 1'b0, link.lin_bus_oe);
    $display("test_enable done");
  endtask : test_enable

  task automatic test_gates;
    user_high = 3'h5;
    user_low = 3'h2;
    tick(16);
    check_val("gate_high", 8'h05, link.gate_high);
    check_val("gate_low", 8'h02, link.gate_low);
    user_low = 3'h3;
    tick(12);
    check_val("gate_high", 8'h04, link.gate_high);
    check_val("gate_low", 8'h02, link.gate_low);
    user_high = 3'h2;
    user_low = 3'h5;
    tick(16);
    check_val("gate_high", 8'h02, link.gate_high);
    check_val("gate_low", 8'h05, link.gate_low);
    $display("test_gates done");
  endtask : test_gates

  task automatic test_fault;
    fault_active = 1'b1;
    tick(6);
    check_bit("fault_latched", 1'b1, fault_latched);
    clear_pulse();
    check_bit("fault_latched", 1'b1, fault_latched);
    fault_active = 1'b0;
    clear_pulse();
    check_bit("fault_latched", 1'b0, fault_latched);
    check_val("mode", MODE_NORMAL, link.mode);
    check_val("gate_high", 8'h02, link.gate_high);
    $display("test_fault done");
  endtask : test_fault

  task automatic test_standby;
    weak_pullup_bit = 1'b0;
    enable_req = 1'b0;
    tick(8);
    check_val("gate_high", 8'h00, link.gate_high);
    check_val("mode", MODE_PENDING, link.mode);
    tick(MDLY + 8);
    check_val("mode", MODE_STANDBY, link.mode);
    check_bit("amps_on", 1'b0, amps_on);
    check_bit("high_reg_on", 1'b0, high_reg_on);
    check_bit("buck_on", 1'b1, buck_on);
    check_bit("low_reg_on", 1'b1, low_reg_on);
    check_bit("lin_pullup_on", 1'b0, link.lin_pullup_on);
    weak_pullup_bit = 1'b1;
    enable_on();
    $display("test_standby done");
  endtask : test_standby

  task automatic test_sleep;
    sleep_select = 1'b1;
    enable_req = 1'b0;
    tick(MDLY + 16);
    check_val("mode", MODE_SLEEP, link.mode);
    check_bit("lin_pullup_on", 1'b0, link.lin_pullup_on);
    enable_on();
    $display("test_sleep done");
  endtask : test_sleep

  task automatic test_lin_wake;
    enable_req = 1'b0;
    tick(MDLY + 16);
    check_val("mode", MODE_SLEEP, link.mode);
    lin_wake_req = 1'b1;
    tick(1);
    lin_wake_req = 1'b0;
    tick(30);
    check_bit("still asleep", 1'b0, link.mode == MODE_SLEEP);
    enable_on();
    $display("test_lin_wake done");
  endtask : test_lin_wake

  task automatic complete_run;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // hang guard: whole sequence needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      complete_run();
    end
  end

  initial
  begin
    tick(2);
    rst = 1'b0;
    tick(4);
    check_val("mode", MODE_STANDBY, link.mode);
    test_enable();
    test_gates();
    test_fault();
    test_standby();
    test_sleep();
    test_lin_wake();
    complete_run();
  end
endmodule : enable_sleep_wake_control_tb_top
